//--- design/timer_channel.sv
`timescale 1ns/1ps
`default_nettype none
module timer_channel #(
  parameter bit PERIODIC = 1'b0
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // Clock source pulses
  input wire logic tickCoreDiv4,
  input wire logic tickHighDiv16,
  input wire logic tickHighDiv64,
  input wire logic tickLow,
  input wire logic extRise,
  input wire logic extFall,
  input wire logic capRise,
  input wire logic capFall,
  // Control
  input wire logic [2:0] clockSourceSelect,
  input wire logic pause,
  input wire logic counterOnControl,
  input wire logic [1:0] mode,
  input wire logic [1:0] outFunction,
  input wire logic initialLevel,
  input wire logic polarity,
  input wire logic dutySwap,
  input wire logic clearOnA,
  input wire logic [timer_pkg::CNT_W-1:0] compareAValue,
  input wire logic [timer_pkg::CNT_W-1:0] comparePValue,
  // Status
  output logic [timer_pkg::CNT_W-1:0] count,
  output logic matchA,
  output logic matchP,
  output logic captured,
  output logic outPin
);
  import timer_pkg::*;

  logic onPrev;
  logic outLevel;
  pulse_e pulseState;
  pulse_e next_pulseState;
  logic [CNT_W-1:0] next_count;
  logic next_outLevel;

  // Clock source selection
  wire srcTick = (clockSourceSelect == CLK_CORE_DIV4) ? tickCoreDiv4 :
                 (clockSourceSelect == CLK_CORE) ? 1'b1 :
                 (clockSourceSelect == CLK_HIGH_DIV16) ? tickHighDiv16 :
                 (clockSourceSelect == CLK_HIGH_DIV64) ? tickHighDiv64 :
                 (clockSourceSelect == CLK_EXT_RISE) ? extRise :
                 (clockSourceSelect == CLK_EXT_FALL) ? extFall : tickLow; // see RL4, RL5

  // Mode decode
  wire onRise = counterOnControl & ~onPrev;
  wire pwmMode = (mode == MODE_PWM);
  wire singleMode = PERIODIC && pwmMode && (outFunction == PWM_SINGLE);
  wire captureMode = PERIODIC && (mode == MODE_CAPTURE);
  wire trigger = singleMode & (extRise | onRise); // see RL6
  wire step = srcTick & counterOnControl & ~pause &
              (~singleMode | (pulseState == PULSE_RUN));

  // Comparators; a period of zero means the full counter range
  wire [CNT_W-1:0] incr = count + {{(CNT_W-1){1'b0}}, 1'b1};
  wire fullRange = (comparePValue == {CNT_W{1'b0}});
  wire hitA = step & ~captureMode & (incr == compareAValue); // see RL1
  wire hitP = step & (fullRange ? (count == {CNT_W{1'b1}}) : (incr == comparePValue));
  // PWM lets dutySwap pick the clearing comparator; the other sets duty, so duty and period are both free
  wire clearByA = singleMode | (pwmMode ? dutySwap : clearOnA); // see RL11
  wire doClear = clearByA ? hitA : hitP; // see RL3
  wire [CNT_W-1:0] duty = dutySwap ? comparePValue : compareAValue;
  wire waveActive = (count < duty);

  // Capture edge qualification
  always_comb begin
    captured = 1'b0;
    if (captureMode & counterOnControl) begin
      case (outFunction)
        CAP_RISE: captured = capRise; // see RL7
        CAP_FALL: captured = capFall; // see RL7
        CAP_BOTH: captured = capRise | capFall; // see RL7
        default: captured = 1'b0;
      endcase
    end
  end

  assign matchA = hitA; // see RL2
  assign matchP = hitP; // see RL2

  // Counter next value
  always_comb begin
    next_count = count;
    if (onRise | trigger) begin
      next_count = {CNT_W{1'b0}}; // see RL19
    end else if (step) begin
      next_count = doClear ? {CNT_W{1'b0}} : incr; // see RL3, RL18
    end
  end

  // Single pulse sequencing
  always_comb begin
    next_pulseState = pulseState;
    case (pulseState)
      PULSE_IDLE: begin
        if (trigger) begin
          next_pulseState = PULSE_RUN;
        end
      end
      PULSE_RUN: begin
        if (hitA | ~singleMode) begin
          next_pulseState = PULSE_IDLE;
        end
      end
      default: next_pulseState = PULSE_IDLE;
    endcase
  end

  // Output level before polarity
  always_comb begin
    next_outLevel = outLevel;
    if (mode == MODE_COMPARE) begin
      if (onRise) begin
        next_outLevel = initialLevel;
      end else if (hitA) begin
        case (outFunction)
          IO_LOW: next_outLevel = 1'b0; // see RL9
          IO_HIGH: next_outLevel = 1'b1; // see RL9
          IO_TOGGLE: next_outLevel = ~outLevel; // see RL9
          default: next_outLevel = outLevel;
        endcase
      end
    end else if (pwmMode) begin
      case (outFunction)
        PWM_ACTIVE: next_outLevel = initialLevel;
        PWM_WAVE: next_outLevel = waveActive ? initialLevel : ~initialLevel; // see RL10
        PWM_SINGLE: next_outLevel = (PERIODIC && next_pulseState == PULSE_RUN) ?
                                    initialLevel : ~initialLevel;
        default: next_outLevel = ~initialLevel;
      endcase
    end
  end

  // State registers
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      count <= {CNT_W{1'b0}};
      onPrev <= 1'b0;
      outLevel <= 1'b0;
      outPin <= 1'b0;
      pulseState <= PULSE_IDLE;
    end else begin
      count <= next_count;
      onPrev <= counterOnControl;
      outLevel <= next_outLevel;
      outPin <= next_outLevel ^ polarity; // see RL10
      pulseState <= next_pulseState;
    end
  end
endmodule
`default_nettype wire

//--- design/timer_module_common_core.sv
// Operation
// RL1: Free-running up-counter compared with comparators; equality is a match.
// RL2: Separate match events for comparator A and comparator P.
// RL3: A match can clear the counter and change the output pin.
// RL4: Three-bit field picks core, high-speed, low-speed or external clock.
// RL5: External clock pin counts on rising or falling edge as chosen.
// RL6: Periodic single pulse mode uses its external pin as trigger.
// RL7: Capture input detects rising, falling or both edges by two-bit field.
// RL8: Periodic capture may take the external clock pin as source.
// RL9: Compare output mode drives output high, low or toggles on match.
// RL10: PWM waveform leaves on the same output pin as compare output.
// RL11: Edge-aligned PWM with either duty or period adjustable, not both; here comparators A and P both stay adjustable.
// RL12: Counter and comparators read as byte pairs; low byte via buffer.
// RL13: Writing a low byte only loads the shared 8-bit buffer.
// RL14: Writing the high byte also moves the buffer into the low byte.
// RL15: Reading the high byte copies the low byte into the buffer.
// RL16: Software writes low then high, reads high then low.
// RL17: Exactly two timers: one compact, one periodic.
// RL18: Counter is ten bits wide and counts upward.
// RL19: Software changes the counter only by raising counter-on, clearing it.
// RL20: Buffer transfer happens at the same edge as the high-byte access.
//
// Design decisions made here: register access over APB and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module timer_module_common_core (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [timer_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Internal clock levels
  input wire logic highSpeedInternalClock,
  input wire logic lowSpeedInternalClock,
  // Timer pins
  input wire logic compactExtClockPin,
  input wire logic periodicExtClockPin,
  input wire logic captureInputPin,
  output logic compactOutputPin,
  output logic periodicOutputPin
);
  import timer_pkg::*;

  // Software registers
  logic [7:0] cCtrl0;
  logic [7:0] cCtrl1;
  logic [CNT_W-1:0] cCmpA;
  logic [BYTE_W-1:0] cBuf;
  logic [1:0] cFlags;
  logic [7:0] pCtrl0;
  logic [7:0] pCtrl1;
  logic [CNT_W-1:0] pCmpA;
  logic [CNT_W-1:0] pCmpP;
  logic [BYTE_W-1:0] pBuf;
  logic [1:0] pFlags;

  // Prescalers and pin history
  logic [CORE_DIV_W-1:0] coreDiv;
  logic [HIGH_DIV_W-1:0] highDiv;
  logic highPrev;
  logic lowPrev;
  logic cExtPrev;
  logic pExtPrev;
  logic capPrev;

  // Timer status
  logic [CNT_W-1:0] cCount;
  logic [CNT_W-1:0] pCount;
  logic cMatchA;
  logic cMatchP;
  logic pMatchA;
  logic pMatchP;
  logic pCaptured;
  logic cCapturedUnused;

  // Clock source pulses
  wire highRise = highSpeedInternalClock & ~highPrev;
  wire tickLow = lowSpeedInternalClock & ~lowPrev;
  wire tickCoreDiv4 = (coreDiv == {CORE_DIV_W{1'b1}});
  wire tickHighDiv16 = highRise & (highDiv[3:0] == 4'hF);
  wire tickHighDiv64 = highRise & (highDiv == {HIGH_DIV_W{1'b1}});
  wire cExtRise = compactExtClockPin & ~cExtPrev;
  wire cExtFall = ~compactExtClockPin & cExtPrev;
  wire pExtRise = periodicExtClockPin & ~pExtPrev;
  wire pExtFall = ~periodicExtClockPin & pExtPrev;
  // Switching the capture source can itself look like an edge
  wire capSource = pCtrl0[CAPSRC_BIT] ? periodicExtClockPin : captureInputPin; // see RL8
  wire capRise = capSource & ~capPrev;
  wire capFall = ~capSource & capPrev;

  // APB phase decode
  wire access = psel & penable;
  wire done = access & pready;
  wire wrDone = done & pwrite;
  wire rdDone = done & ~pwrite;
  wire firstAccess = access & ~pready;

  // Address decode
  wire selCCtrl0 = (paddr == OFF_C_CTRL0);
  wire selCCtrl1 = (paddr == OFF_C_CTRL1);
  wire selCCntLo = (paddr == OFF_C_CNT_LO);
  wire selCCntHi = (paddr == OFF_C_CNT_HI);
  wire selCALo = (paddr == OFF_C_A_LO);
  wire selCAHi = (paddr == OFF_C_A_HI);
  wire selCStatus = (paddr == OFF_C_STATUS);
  wire selPCtrl0 = (paddr == OFF_P_CTRL0);
  wire selPCtrl1 = (paddr == OFF_P_CTRL1);
  wire selPCntLo = (paddr == OFF_P_CNT_LO);
  wire selPCntHi = (paddr == OFF_P_CNT_HI);
  wire selPALo = (paddr == OFF_P_A_LO);
  wire selPAHi = (paddr == OFF_P_A_HI);
  wire selPPLo = (paddr == OFF_P_P_LO);
  wire selPPHi = (paddr == OFF_P_P_HI);
  wire selPStatus = (paddr == OFF_P_STATUS);
  wire mapped = selCCtrl0 | selCCtrl1 | selCCntLo | selCCntHi | selCALo | selCAHi |
                selCStatus | selPCtrl0 | selPCtrl1 | selPCntLo | selPCntHi |
                selPALo | selPAHi | selPPLo | selPPHi | selPStatus;

  // Read data; low bytes always come from the buffer
  wire [7:0] rdByte = selCCtrl0 ? cCtrl0 :
                      selCCtrl1 ? cCtrl1 :
                      (selCCntLo | selCALo) ? cBuf : // see RL12
                      selCCntHi ? {6'h00, cCount[9:8]} : // see RL12
                      selCAHi ? {6'h00, cCmpA[9:8]} :
                      selCStatus ? {6'h00, cFlags} :
                      selPCtrl0 ? pCtrl0 :
                      selPCtrl1 ? pCtrl1 :
                      (selPCntLo | selPALo | selPPLo) ? pBuf : // see RL12
                      selPCntHi ? {6'h00, pCount[9:8]} :
                      selPAHi ? {6'h00, pCmpA[9:8]} :
                      selPPHi ? {6'h00, pCmpP[9:8]} :
                      selPStatus ? {6'h00, pFlags} : 8'h00;

  // Buffer next values; order of accesses is left to software
  wire [7:0] next_cBuf = (wrDone & selCALo) ? pwdata[7:0] : // see RL13, RL16
                         (rdDone & selCCntHi) ? cCount[7:0] : // see RL15, RL20
                         (rdDone & selCAHi) ? cCmpA[7:0] : cBuf; // see RL15
  wire [7:0] next_pBuf = (wrDone & (selPALo | selPPLo)) ? pwdata[7:0] : // see RL13
                         (rdDone & selPCntHi) ? pCount[7:0] : // see RL15, RL20
                         (rdDone & selPAHi) ? pCmpA[7:0] :
                         (rdDone & selPPHi) ? pCmpP[7:0] : pBuf; // see RL15

  // Comparator next values; a capture beats a software write
  wire [CNT_W-1:0] next_cCmpA = (wrDone & selCAHi) ? {pwdata[1:0], cBuf} : cCmpA; // see RL14
  wire [CNT_W-1:0] next_pCmpA = pCaptured ? pCount :
                                (wrDone & selPAHi) ? {pwdata[1:0], pBuf} : pCmpA; // see RL14
  wire [CNT_W-1:0] next_pCmpP = (wrDone & selPPHi) ? {pwdata[1:0], pBuf} : pCmpP; // see RL14

  // Event flags, write one to clear; a new event wins over the clear
  wire [1:0] cClear = (wrDone & selCStatus) ? pwdata[1:0] : 2'h0;
  wire [1:0] pClear = (wrDone & selPStatus) ? pwdata[1:0] : 2'h0;
  wire [1:0] next_cFlags = (cFlags & ~cClear) | {cMatchP, cMatchA};
  wire [1:0] next_pFlags = (pFlags & ~pClear) | {pMatchP, pMatchA | pCaptured};

  // Compact period is a 3-bit field above seven zero bits
  wire [CNT_W-1:0] cPeriod = {cCtrl0[CPER_LSB+2:CPER_LSB], {CPER_SHIFT{1'b0}}};

  // Compact timer
  timer_channel #(
    .PERIODIC(1'b0)
  ) compactTimer ( // see RL17
    .mclk(mclk),
    .reset_n(reset_n),
    .tickCoreDiv4(tickCoreDiv4),
    .tickHighDiv16(tickHighDiv16),
    .tickHighDiv64(tickHighDiv64),
    .tickLow(tickLow),
    .extRise(cExtRise),
    .extFall(cExtFall),
    .capRise(1'b0),
    .capFall(1'b0),
    .clockSourceSelect(cCtrl0[CLKSEL_LSB+2:CLKSEL_LSB]),
    .pause(cCtrl0[PAUSE_BIT]),
    .counterOnControl(cCtrl0[ON_BIT]),
    .mode(cCtrl1[MODE_LSB+1:MODE_LSB]),
    .outFunction(cCtrl1[IO_LSB+1:IO_LSB]),
    .initialLevel(cCtrl1[OC_BIT]),
    .polarity(cCtrl1[POL_BIT]),
    .dutySwap(cCtrl1[DPX_BIT]),
    .clearOnA(cCtrl1[CCLR_BIT]),
    .compareAValue(cCmpA),
    .comparePValue(cPeriod),
    .count(cCount),
    .matchA(cMatchA),
    .matchP(cMatchP),
    .captured(cCapturedUnused),
    .outPin(compactOutputPin)
  );

  // Periodic timer
  timer_channel #(
    .PERIODIC(1'b1)
  ) periodicTimer ( // see RL17
    .mclk(mclk),
    .reset_n(reset_n),
    .tickCoreDiv4(tickCoreDiv4),
    .tickHighDiv16(tickHighDiv16),
    .tickHighDiv64(tickHighDiv64),
    .tickLow(tickLow),
    .extRise(pExtRise),
    .extFall(pExtFall),
    .capRise(capRise),
    .capFall(capFall),
    .clockSourceSelect(pCtrl0[CLKSEL_LSB+2:CLKSEL_LSB]),
    .pause(pCtrl0[PAUSE_BIT]),
    .counterOnControl(pCtrl0[ON_BIT]),
    .mode(pCtrl1[MODE_LSB+1:MODE_LSB]),
    .outFunction(pCtrl1[IO_LSB+1:IO_LSB]),
    .initialLevel(pCtrl1[OC_BIT]),
    .polarity(pCtrl1[POL_BIT]),
    .dutySwap(pCtrl1[DPX_BIT]),
    .clearOnA(pCtrl1[CCLR_BIT]),
    .compareAValue(pCmpA),
    .comparePValue(pCmpP),
    .count(pCount),
    .matchA(pMatchA),
    .matchP(pMatchP),
    .captured(pCaptured),
    .outPin(periodicOutputPin)
  );

  // APB handshake: one wait state, data registered on the same edge as pready
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= firstAccess;
      pslverr <= firstAccess & ~mapped;
      if (firstAccess & ~pwrite) begin
        prdata <= {24'h000000, rdByte};
      end
    end
  end

  // Prescalers and edge history
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      coreDiv <= {CORE_DIV_W{1'b0}};
      highDiv <= {HIGH_DIV_W{1'b0}};
      highPrev <= 1'b0;
      lowPrev <= 1'b0;
      cExtPrev <= 1'b0;
      pExtPrev <= 1'b0;
      capPrev <= 1'b0;
    end else begin
      coreDiv <= coreDiv + {{(CORE_DIV_W-1){1'b0}}, 1'b1};
      if (highRise) begin
        highDiv <= highDiv + {{(HIGH_DIV_W-1){1'b0}}, 1'b1};
      end
      highPrev <= highSpeedInternalClock;
      lowPrev <= lowSpeedInternalClock;
      cExtPrev <= compactExtClockPin;
      pExtPrev <= periodicExtClockPin;
      capPrev <= capSource;
    end
  end

  // Control registers
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cCtrl0 <= CTRL_RESET;
      cCtrl1 <= CTRL_RESET;
      pCtrl0 <= CTRL_RESET;
      pCtrl1 <= CTRL_RESET;
    end else if (wrDone) begin
      if (selCCtrl0) cCtrl0 <= pwdata[7:0];
      if (selCCtrl1) cCtrl1 <= pwdata[7:0];
      if (selPCtrl0) pCtrl0 <= pwdata[7:0];
      if (selPCtrl1) pCtrl1 <= pwdata[7:0];
    end
  end

  // Buffers, comparators and flags
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cBuf <= 8'h00;
      pBuf <= 8'h00;
      cCmpA <= CMP_RESET;
      pCmpA <= CMP_RESET;
      pCmpP <= CMP_RESET;
      cFlags <= FLAGS_RESET;
      pFlags <= FLAGS_RESET;
    end else begin
      cBuf <= next_cBuf;
      pBuf <= next_pBuf;
      cCmpA <= next_cCmpA;
      pCmpA <= next_pCmpA;
      pCmpP <= next_pCmpP;
      cFlags <= next_cFlags;
      pFlags <= next_pFlags;
    end
  end
endmodule
`default_nettype wire

//--- pkg/timer_pkg.sv
`default_nettype none
package timer_pkg;
  // Widths
  localparam int CNT_W = 10;
  localparam int BYTE_W = 8;
  localparam int ADDR_W = 8;
  localparam int HIGH_DIV_W = 6;
  localparam int CORE_DIV_W = 2;

  // Register byte offsets, compact timer
  localparam logic [7:0] OFF_C_CTRL0 = 8'h00;
  localparam logic [7:0] OFF_C_CTRL1 = 8'h04;
  localparam logic [7:0] OFF_C_CNT_LO = 8'h08;
  localparam logic [7:0] OFF_C_CNT_HI = 8'h0C;
  localparam logic [7:0] OFF_C_A_LO = 8'h10;
  localparam logic [7:0] OFF_C_A_HI = 8'h14;
  localparam logic [7:0] OFF_C_STATUS = 8'h18;
  // Register byte offsets, periodic timer
  localparam logic [7:0] OFF_P_CTRL0 = 8'h20;
  localparam logic [7:0] OFF_P_CTRL1 = 8'h24;
  localparam logic [7:0] OFF_P_CNT_LO = 8'h28;
  localparam logic [7:0] OFF_P_CNT_HI = 8'h2C;
  localparam logic [7:0] OFF_P_A_LO = 8'h30;
  localparam logic [7:0] OFF_P_A_HI = 8'h34;
  localparam logic [7:0] OFF_P_P_LO = 8'h38;
  localparam logic [7:0] OFF_P_P_HI = 8'h3C;
  localparam logic [7:0] OFF_P_STATUS = 8'h40;

  // Control 0 fields
  localparam int PAUSE_BIT = 7;
  localparam int CLKSEL_LSB = 4;
  localparam int ON_BIT = 3;
  localparam int CPER_LSB = 0;
  localparam int CAPSRC_BIT = 0;
  // Control 1 fields
  localparam int MODE_LSB = 6;
  localparam int IO_LSB = 4;
  localparam int OC_BIT = 3;
  localparam int POL_BIT = 2;
  localparam int DPX_BIT = 1;
  localparam int CCLR_BIT = 0;
  // Status fields
  localparam int FLAG_A_BIT = 0;
  localparam int FLAG_P_BIT = 1;
  // Low bits of the compact period that the 3-bit field sits above
  localparam int CPER_SHIFT = 7;

  // Reset values
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [9:0] CMP_RESET = 10'h000;
  localparam logic [1:0] FLAGS_RESET = 2'h0;

  // Clock source codes
  localparam logic [2:0] CLK_CORE_DIV4 = 3'h0;
  localparam logic [2:0] CLK_CORE = 3'h1;
  localparam logic [2:0] CLK_HIGH_DIV16 = 3'h2;
  localparam logic [2:0] CLK_HIGH_DIV64 = 3'h3;
  localparam logic [2:0] CLK_LOW_A = 3'h4;
  localparam logic [2:0] CLK_LOW_B = 3'h5;
  localparam logic [2:0] CLK_EXT_RISE = 3'h6;
  localparam logic [2:0] CLK_EXT_FALL = 3'h7;

  // Operating modes
  localparam logic [1:0] MODE_COMPARE = 2'h0;
  localparam logic [1:0] MODE_CAPTURE = 2'h1;
  localparam logic [1:0] MODE_PWM = 2'h2;
  localparam logic [1:0] MODE_TIMER = 2'h3;

  // Output function codes: compare mode, PWM mode, capture edge
  localparam logic [1:0] IO_NONE = 2'h0;
  localparam logic [1:0] IO_LOW = 2'h1;
  localparam logic [1:0] IO_HIGH = 2'h2;
  localparam logic [1:0] IO_TOGGLE = 2'h3;
  localparam logic [1:0] PWM_INACTIVE = 2'h0;
  localparam logic [1:0] PWM_ACTIVE = 2'h1;
  localparam logic [1:0] PWM_WAVE = 2'h2;
  localparam logic [1:0] PWM_SINGLE = 2'h3;
  localparam logic [1:0] CAP_RISE = 2'h0;
  localparam logic [1:0] CAP_FALL = 2'h1;
  localparam logic [1:0] CAP_BOTH = 2'h2;

  // Single pulse sequencing
  typedef enum logic {PULSE_IDLE, PULSE_RUN} pulse_e;
endpackage
`default_nettype wire

//--- sim/tb_timer_module_common_core.sv
`timescale 1ns/1ps
`default_nettype none
module tb_timer_module_common_core;
  import timer_pkg::*;
  logic mclk, reset_n, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr, b, s;
  logic [31:0] pwdata, prdata, seed;
  logic hs, ls, cExt, pExt, capPin, cOut, pOut;
  logic [9:0] note, v;
  logic [9:0] expQ[$];
  logic [7:0] pairLo[3] = '{OFF_C_A_LO, OFF_P_A_LO, OFF_P_P_LO};
  int n_errors = 0;
  int num_checks = 0;
  timer_module_common_core timer_module_common_core_inst (.mclk(mclk), .reset_n(reset_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .highSpeedInternalClock(hs),
    .lowSpeedInternalClock(ls), .compactExtClockPin(cExt), .periodicExtClockPin(pExt),
    .captureInputPin(capPin), .compactOutputPin(cOut), .periodicOutputPin(pOut));
  timer_pin_model pins (.mclk(mclk), .highSpeedInternalClock(hs), .lowSpeedInternalClock(ls),
    .compactExtClockPin(cExt), .periodicExtClockPin(pExt), .captureInputPin(capPin));
  always #4 mclk = ~mclk;
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  task automatic tally_and_finish();
    if (n_errors == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Note holds {check data, expect error, data}; the monitor pops it
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
    input logic [9:0] n);
    expQ.push_back(n);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    xfer(1'b1, a, d, 10'h000);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    xfer(1'b0, a, 8'h00, {2'b10, e});
  endtask
  // Pair order: low then high on write, high then low on read
  task automatic w10(input logic [7:0] lo, input logic [9:0] x);
    wr(lo, x[7:0]);
    wr(lo + 8'h04, {6'h00, x[9:8]});
  endtask
  task automatic r10(input logic [7:0] lo, input logic [9:0] x);
    rd(lo + 8'h04, {6'h00, x[9:8]});
    rd(lo, x[7:0]);
  endtask
  task automatic chk(input logic got, input logic e);
    num_checks++;
    if (got !== e) begin
      n_errors++;
      $display("[ERR] %0t output pin %b", $time, got);
    end
  endtask
  // Answer monitor
  always @(posedge mclk) begin
    if (psel && penable && pready === 1'b1) begin
      note = expQ.pop_front();
      num_checks++;
      if (pslverr !== note[8] || (note[9] && prdata !== {24'h000000, note[7:0]})) begin
        n_errors++;
        $display("[ERR] %0t answer %h err %b", $time, prdata, pslverr);
      end
    end
  end
  // Hang guard, far beyond the expected run
  initial begin
    repeat (20000) @(posedge mclk);
    n_errors++;
    tally_and_finish();
  end
  initial begin
    mclk = 1'b0;
    reset_n = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    seed = 32'hBB3394F7;
    repeat (3) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
    rd(OFF_C_CTRL0, 8'h00);
    rd(OFF_P_STATUS, 8'h00);
    xfer(1'b0, 8'h1C, 8'h00, 10'h300);
    xfer(1'b1, 8'h44, 8'hFF, 10'h100);
    for (int i = 0; i < 3; i++) begin
      seed = xs(seed);
      v = seed[9:0];
      w10(pairLo[i], v);
      r10(pairLo[i], v);
      wr(pairLo[i], ~v[7:0]);
      r10(pairLo[i], v);
    end
    w10(OFF_P_P_LO, 10'h000);
    for (int t = 0; t < 4; t++) begin
      b = t[1] ? 8'h20 : 8'h00;
      wr(b, 8'h00);
      wr(b + 8'h04, {MODE_TIMER, 6'h00});
      wr(b, {1'b0, t[0] ? CLK_EXT_FALL : CLK_EXT_RISE, 4'h8});
      pins.ext_set(1'b1);
      r10(b + 8'h08, {9'h000, !t[0]});
      pins.ext_set(1'b0);
      pins.ext_pulses(3);
      r10(b + 8'h08, 10'h004);
    end
    for (int t = 0; t < 6; t++) begin
      b = t > 2 ? 8'h20 : 8'h00;
      s = t > 2 ? OFF_P_STATUS : OFF_C_STATUS;
      wr(b, 8'h00);
      w10(b + 8'h10, 10'h003);
      wr(b + 8'h04, {MODE_COMPARE, 2'(t % 3 + 1), t % 3 == 0, 3'h1});
      wr(b, {1'b0, CLK_EXT_RISE, 4'h8});
      pins.ext_pulses(3);
      chk(t > 2 ? pOut : cOut, t % 3 != 0);
      rd(s, 8'h01);
      wr(s, 8'h01);
      rd(s, 8'h00);
      pins.ext_pulses(3);
      chk(t > 2 ? pOut : cOut, t % 3 == 1);
      r10(b + 8'h08, 10'h000);
    end
    for (int c = 0; c < 3; c++) begin
      wr(OFF_P_CTRL0, 8'h00);
      wr(OFF_P_CTRL1, {MODE_CAPTURE, 2'(c), 4'h0});
      wr(OFF_P_CTRL0, {1'b0, CLK_EXT_RISE, 4'h8});
      wr(OFF_P_STATUS, 8'h03);
      pins.cap_set(1'b1);
      rd(OFF_P_STATUS, {7'h00, c != 1});
      wr(OFF_P_STATUS, 8'h03);
      pins.cap_set(1'b0);
      rd(OFF_P_STATUS, {7'h00, c != 0});
    end
    wr(OFF_P_CTRL0, 8'h00);
    wr(OFF_P_CTRL1, {MODE_CAPTURE, CAP_RISE, 4'h0});
    wr(OFF_P_CTRL0, {1'b0, CLK_EXT_FALL, 4'h9});
    wr(OFF_P_STATUS, 8'h03);
    pins.ext_set(1'b1);
    rd(OFF_P_STATUS, 8'h01);
    pins.ext_set(1'b0);
    for (int d = 0; d < 2; d++) begin
      wr(OFF_P_CTRL0, 8'h00);
      w10(OFF_P_P_LO, d ? 10'h002 : 10'h004);
      w10(OFF_P_A_LO, d ? 10'h004 : 10'h002);
      wr(OFF_P_CTRL1, {MODE_PWM, PWM_WAVE, 2'h2, d[0], 1'b0});
      wr(OFF_P_CTRL0, {1'b0, CLK_EXT_RISE, 4'h8});
      pins.ext_pulses(2);
      chk(pOut, 1'b0);
      pins.ext_pulses(2);
      chk(pOut, 1'b1);
    end
    // Core clock: count runs three edges from clear until the pause write lands
    wr(OFF_P_CTRL0, 8'h00);
    wr(OFF_P_CTRL1, {MODE_TIMER, 6'h01});
    wr(OFF_P_CTRL0, {1'b0, CLK_CORE, 4'h8});
    wr(OFF_P_CTRL0, {1'b1, CLK_CORE, 4'h8});
    r10(OFF_P_CNT_LO, 10'h003);
    // Single pulse: ends at A match, restarted by the external pin
    wr(OFF_P_CTRL0, 8'h00);
    wr(OFF_P_CTRL1, {MODE_PWM, PWM_SINGLE, 4'h8});
    wr(OFF_P_CTRL0, {1'b0, CLK_CORE, 4'h8});
    pins.ext_set(1'b0);
    chk(pOut, 1'b0);
    pins.ext_set(1'b1);
    chk(pOut, 1'b1);
    pins.ext_set(1'b0);
    chk(pOut, 1'b0);
    tally_and_finish();
  end
endmodule
bind timer_module_common_core timer_core_properties timer_core_properties_inst (.mclk(mclk),
  .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr));
`default_nettype wire

//--- sim/timer_core_properties.sv
`timescale 1ns/1ps
`default_nettype none
module timer_core_properties
  import timer_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // APB slave side
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  // Decode of the word map; 0x1C is the hole between the two timers
  wire logic mapped = paddr[1:0] == 2'h0 && paddr <= OFF_P_STATUS && paddr != 8'h1C;
  wire logic hiReg = paddr == OFF_C_CNT_HI || paddr == OFF_C_A_HI || paddr == OFF_P_CNT_HI
    || paddr == OFF_P_A_HI || paddr == OFF_P_P_HI;
  wire logic rdDone = pready && !pwrite;
  a_one_wait_state: assert property ($rose(psel && penable) |-> !pready ##1 pready)
    else $error("ready not in second access cycle");
  a_ready_single: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_ready_in_access: assert property (pready |-> psel && penable)
    else $error("ready outside access phase");
  a_err_on_hole: assert property (pready |-> pslverr == !mapped)
    else $error("error response wrong for address");
  a_err_read_zero: assert property (rdDone && pslverr |-> prdata == 32'h0)
    else $error("refused read not zero");
  a_byte_wide: assert property (rdDone |-> prdata[31:8] == 24'h0)
    else $error("read data wider than a byte");
  a_high_two_bits: assert property (rdDone && hiReg |-> prdata[31:2] == 30'h0)
    else $error("high byte wider than two bits");
  a_rdata_holds: assert property ($changed(prdata) |-> rdDone)
    else $error("read data moved without a read");
  // Main traffic kinds
  c_high_read: cover property (rdDone && hiReg);
  c_refused: cover property (pready && pslverr);
  c_back_to_back: cover property (pready ##1 psel ##1 psel && penable);
endmodule
`default_nettype wire

//--- sim/timer_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
module timer_pin_model (
  // Clock
  input wire logic mclk,
  // Pins toward the timers
  output logic highSpeedInternalClock,
  output logic lowSpeedInternalClock,
  output logic compactExtClockPin,
  output logic periodicExtClockPin,
  output logic captureInputPin
);
  logic [3:0] div = 4'h0;
  logic extLevel = 1'b0;
  // Internal clocks run free; pins move only on request
  always @(posedge mclk) begin
    div <= div + 4'h1;
  end
  assign highSpeedInternalClock = div[0];
  assign lowSpeedInternalClock = div[3];
  assign compactExtClockPin = extLevel;
  assign periodicExtClockPin = extLevel;
  initial captureInputPin = 1'b0;
  // Hold each level long enough for the one-cycle-late sampler
  task automatic ext_set(input logic v);
    @(posedge mclk);
    extLevel <= v;
    repeat (4) @(posedge mclk);
  endtask
  task automatic ext_pulses(input int n);
    repeat (n) begin
      ext_set(1'b1);
      ext_set(1'b0);
    end
  endtask
  task automatic cap_set(input logic v);
    @(posedge mclk);
    captureInputPin <= v;
    repeat (4) @(posedge mclk);
  endtask
endmodule
`default_nettype wire
